// file: core/vfe_pkg.sv
// shared constants and types for the vector feature enumeration block
package vfe_pkg;
    // feature query leaves and result word bits
    localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
    localparam logic [31:0] LEAF_EXT = 32'h0000_0007;
    localparam logic [31:0] SUBLEAF_ZERO = 32'h0000_0000;
    localparam int BIT_OS_STATE = 27;
    localparam int BIT_STATE_SAVE = 26;
    localparam int BIT_FOUNDATION = 16;
    localparam int BIT_DWORD_QWORD = 17;
    localparam int BIT_GATHER_PF = 26;
    localparam int BIT_EXP_RECIP = 27;
    localparam int BIT_CONFLICT = 28;
    localparam int BIT_BYTE_WORD = 30;
    localparam int BIT_REDUCED_LEN = 31;
    // extended-state enable register fields
    localparam int XE_LEGACY_FP = 0;
    localparam int XE_SHORT_LO = 1;
    localparam int XE_MID_HI = 2;
    localparam int XE_OPMASK_LO = 5;
    localparam int XE_WIDE_HI = 7;
    localparam logic [63:0] XE_RESET = 64'h0000_0000_0000_0001;
    localparam logic [63:0] XE_WRITABLE = 64'h0000_0000_0000_00E7;
    localparam logic [2:0] XE_WIDE_ALL = 3'h7;
    localparam logic [1:0] XE_NARROW_ALL = 2'h3;
    localparam int NUM_OPMASK = 8;
    // register bus offsets
    localparam logic [7:0] ADDR_QUERY_LEAF = 8'h00;
    localparam logic [7:0] ADDR_QUERY_SUB = 8'h04;
    localparam logic [7:0] ADDR_RES_A = 8'h08;
    localparam logic [7:0] ADDR_RES_B = 8'h0C;
    localparam logic [7:0] ADDR_RES_C = 8'h10;
    localparam logic [7:0] ADDR_RES_D = 8'h14;
    localparam logic [7:0] ADDR_XE_LO = 8'h18;
    localparam logic [7:0] ADDR_XE_HI = 8'h1C;
    localparam logic [7:0] ADDR_XE_WRITE = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_CHECK = 8'h28;
    localparam logic [7:0] ADDR_VERDICT = 8'h2C;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
    // vector length field codes
    localparam logic [1:0] VL_128 = 2'h0;
    localparam logic [1:0] VL_256 = 2'h1;
    localparam logic [1:0] VL_512 = 2'h2;
    // instruction groups presented for a legality check
    typedef enum logic [2:0] {
        VFE_GRP_FOUND = 3'h0,
        VFE_GRP_CONFLICT = 3'h1,
        VFE_GRP_DQ = 3'h2,
        VFE_GRP_BW = 3'h3,
        VFE_GRP_ER = 3'h4,
        VFE_GRP_PF = 3'h5,
        VFE_GRP_OPMASK = 3'h6,
        VFE_GRP_L1PF = 3'h7
    } vfe_group_e;
    // one instruction offered for checking
    typedef struct packed {
        vfe_group_e group;
        logic [1:0] vlen;
        logic wide_only;    // form that exists only at 512 and 256
        logic gpr_operand;  // opmask form using one general register
        logic other_operand; // operand neither opmask nor general register
        logic [2:0] mask_sel;
    } vfe_instr_s;
    // answer of a legality check
    typedef struct packed {
        logic valid;
        logic fault;
        logic [2:0] mask_sel;
    } vfe_verdict_s;
    // capability straps of the implementation
    typedef struct packed {
        logic foundation;
        logic exp_recip;
        logic gather_pf;
        logic conflict;
        logic dword_qword;
        logic byte_word;
        logic reduced_len;
        logic state_save;
    } vfe_caps_s;
endpackage

// file: core/vfe_query.sv
// feature query result words from leaf, subleaf and enable state
`timescale 1ns/1ps
module vfe_query
    import vfe_pkg::*;
(
    input wire logic [31:0] leaf,
    input wire logic [31:0] subleaf,
    input wire vfe_caps_s caps,
    input wire logic os_state_mgmt_enabled_flag,
    output logic [31:0] res_a,
    output logic [31:0] res_b,
    output logic [31:0] res_c,
    output logic [31:0] res_d
);
    // assemble result words; unknown leaves return zero
    always_comb
    begin
        res_a = 32'h0000_0000;
        res_b = 32'h0000_0000;
        res_c = 32'h0000_0000;
        res_d = 32'h0000_0000;
        if (leaf == LEAF_BASIC)
        begin
            res_c[BIT_STATE_SAVE] = caps.state_save;
            res_c[BIT_OS_STATE] = caps.state_save & os_state_mgmt_enabled_flag;
        end
        else if (leaf == LEAF_EXT && subleaf == SUBLEAF_ZERO)
        begin
            res_b[BIT_FOUNDATION] = caps.foundation;
            res_b[BIT_EXP_RECIP] = caps.exp_recip & caps.foundation;
            res_b[BIT_GATHER_PF] = caps.gather_pf & caps.foundation;
            res_b[BIT_CONFLICT] = caps.conflict & caps.foundation;
            res_b[BIT_DWORD_QWORD] = caps.dword_qword & caps.foundation;
            res_b[BIT_BYTE_WORD] = caps.byte_word & caps.foundation;
            res_b[BIT_REDUCED_LEN] = caps.reduced_len & caps.foundation;
        end
    end
endmodule

// file: core/vfe_check.sv
// legality check of one wide-vector instruction against state and caps
`timescale 1ns/1ps
module vfe_check
    import vfe_pkg::*;
(
    input wire vfe_instr_s instr,
    input wire vfe_caps_s caps,
    input wire logic [63:0] xe,
    output logic fault
);
    logic state_ok;
    logic group_ok;
    logic len_ok;
    logic oper_ok;
    // enable fields, group support, length and operand checks
    always_comb
    begin
        state_ok = (xe[XE_WIDE_HI:XE_OPMASK_LO] == XE_WIDE_ALL)
            && (xe[XE_MID_HI:XE_SHORT_LO] == XE_NARROW_ALL);
        case (instr.group)
            VFE_GRP_FOUND: group_ok = caps.foundation;
            VFE_GRP_CONFLICT: group_ok = caps.foundation & caps.conflict;
            VFE_GRP_DQ: group_ok = caps.foundation & caps.dword_qword;
            VFE_GRP_BW: group_ok = caps.foundation & caps.byte_word;
            VFE_GRP_ER: group_ok = caps.foundation & caps.exp_recip;
            VFE_GRP_PF: group_ok = caps.foundation & caps.gather_pf;
            VFE_GRP_OPMASK: group_ok = caps.foundation;
            default: group_ok = 1'b1;
        endcase
        // reduced lengths need the length flag and no narrowed special form
        if (instr.vlen == VL_512)
            len_ok = 1'b1;
        else if (instr.vlen == VL_256)
            len_ok = caps.reduced_len && instr.group != VFE_GRP_ER
                && instr.group != VFE_GRP_PF;
        else if (instr.vlen == VL_128)
            len_ok = caps.reduced_len && !instr.wide_only && instr.group != VFE_GRP_ER
                && instr.group != VFE_GRP_PF;
        else
            len_ok = 1'b0;
        // opmask forms take opmask registers or one general register only
        oper_ok = !(instr.group == VFE_GRP_OPMASK && instr.other_operand);
        if (instr.group == VFE_GRP_L1PF)
            fault = 1'b0; // prefetch needs no enabled state
        else
            fault = !(state_ok && group_ok && len_ok && oper_ok);
    end
endmodule

// file: core/vfe_top.sv
// vector feature enumeration: query words, enable register, legality check
`timescale 1ns/1ps
module vfe_top
    import vfe_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic privileged,
    input wire logic os_state_mgmt_enabled_flag,
    input wire vfe_caps_s caps,
    output logic [31:0] rdata,
    output logic enable_write_fault,
    output logic [NUM_OPMASK-1:0] opmask_state_live,
    output logic wide_state_live
);
    logic [31:0] query_leaf;
    logic [31:0] query_sub;
    logic [63:0] extended_state_enable_reg;
    logic [31:0] pend_hi;
    vfe_instr_s check_instr;
    vfe_verdict_s verdict;
    logic [31:0] res_a;
    logic [31:0] res_b;
    logic [31:0] res_c;
    logic [31:0] res_d;
    logic check_fault;
    logic os_flag_q1;
    logic os_flag_q2;
    logic [63:0] next_xe;
    logic xe_state_ok;

    // address decode helper for writes and reads
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // the os flag comes from another domain, two stages
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            os_flag_q1 <= 1'b0;
            os_flag_q2 <= 1'b0;
        end
        else
        begin
            os_flag_q1 <= os_state_mgmt_enabled_flag;
            os_flag_q2 <= os_flag_q1;
        end
    end

    vfe_query u_query (
        .leaf(query_leaf),
        .subleaf(query_sub),
        .caps(caps),
        .os_state_mgmt_enabled_flag(os_flag_q2),
        .res_a(res_a),
        .res_b(res_b),
        .res_c(res_c),
        .res_d(res_d)
    );

    vfe_check u_check (
        .instr(check_instr),
        .caps(caps),
        .xe(extended_state_enable_reg),
        .fault(check_fault)
    );

    // query leaf and subleaf selection
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            query_leaf <= 32'h0000_0000;
            query_sub <= 32'h0000_0000;
        end
        else if (wr_en && hit(addr, ADDR_QUERY_LEAF))
            query_leaf <= wdata;
        else if (wr_en && hit(addr, ADDR_QUERY_SUB))
            query_sub <= wdata;
    end

    // candidate enable value: legacy fp always on, only known fields kept
    always_comb
    begin
        next_xe = ({pend_hi, wdata} & XE_WRITABLE) | XE_RESET;
    end

    // high half staged, commit on the low write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_hi <= 32'h0000_0000;
        else if (wr_en && hit(addr, ADDR_XE_HI))
            pend_hi <= wdata;
    end

    // enable register; write needs privilege and the state save capability
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extended_state_enable_reg <= XE_RESET;
            enable_write_fault <= 1'b0;
        end
        else
        begin
            enable_write_fault <= 1'b0;
            if (wr_en && hit(addr, ADDR_XE_WRITE))
            begin
                if (privileged && caps.state_save)
                    extended_state_enable_reg <= next_xe;
                else
                    enable_write_fault <= 1'b1;
            end
        end
    end

    // instruction offered for checking, verdict one cycle on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            check_instr <= '0;
            verdict <= '0;
        end
        else
        begin
            if (wr_en && hit(addr, ADDR_CHECK))
                check_instr <= vfe_instr_s'(wdata[$bits(vfe_instr_s)-1:0]);
            verdict.valid <= 1'b1;
            verdict.fault <= check_fault;
            verdict.mask_sel <= check_instr.mask_sel;
        end
    end

    // live state outputs: wide state and eight opmasks usable
    always_comb
    begin
        xe_state_ok = (extended_state_enable_reg[XE_WIDE_HI:XE_OPMASK_LO] == XE_WIDE_ALL)
            && (extended_state_enable_reg[XE_MID_HI:XE_SHORT_LO] == XE_NARROW_ALL);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wide_state_live <= 1'b0;
            opmask_state_live <= '0;
        end
        else
        begin
            wide_state_live <= xe_state_ok & caps.foundation;
            opmask_state_live <= {NUM_OPMASK{xe_state_ok & caps.foundation}};
        end
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= READ_UNMAPPED;
        else if (rd_en)
        begin
            if (hit(addr, ADDR_QUERY_LEAF))
                rdata <= query_leaf;
            else if (hit(addr, ADDR_QUERY_SUB))
                rdata <= query_sub;
            else if (hit(addr, ADDR_RES_A))
                rdata <= res_a;
            else if (hit(addr, ADDR_RES_B))
                rdata <= res_b;
            else if (hit(addr, ADDR_RES_C))
                rdata <= res_c;
            else if (hit(addr, ADDR_RES_D))
                rdata <= res_d;
            else if (hit(addr, ADDR_XE_LO) && os_flag_q2)
                rdata <= extended_state_enable_reg[31:0]; // read allowed once enabled
            else if (hit(addr, ADDR_XE_HI) && os_flag_q2)
                rdata <= extended_state_enable_reg[63:32];
            else if (hit(addr, ADDR_STATUS))
                rdata <= {29'h0, enable_write_fault, os_flag_q2, xe_state_ok};
            else if (hit(addr, ADDR_CHECK))
                rdata <= {{(32-$bits(vfe_instr_s)){1'b0}}, check_instr};
            else if (hit(addr, ADDR_VERDICT))
                rdata <= {{(32-$bits(vfe_verdict_s)){1'b0}}, verdict};
            else
                rdata <= READ_UNMAPPED;
        end
        else
            rdata <= READ_UNMAPPED;
    end
endmodule

// file: bench/vfe_props_properties.sv
// port-level assertions for the vector feature enumeration top
`timescale 1ns/1ps
module vfe_props
    import vfe_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic privileged,
    input wire logic os_state_mgmt_enabled_flag,
    input wire vfe_caps_s caps,
    input wire logic [31:0] rdata,
    input wire logic enable_write_fault,
    input wire logic [NUM_OPMASK-1:0] opmask_state_live,
    input wire logic wide_state_live
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // enable register commit strobe
    wire xe_wr = wr_en && addr == ADDR_XE_WRITE;
    property p_refuse_pulse;
        xe_wr && !privileged |=> enable_write_fault;
    endproperty
    a_refuse_pulse: assert property (p_refuse_pulse) else $error("refused write not flagged");
    property p_fault_cause;
        enable_write_fault |-> $past(xe_wr && !(privileged && caps.state_save));
    endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault without refused write");
    property p_mask_map;
        opmask_state_live == {NUM_OPMASK{wide_state_live}};
    endproperty
    a_mask_map: assert property (p_mask_map) else $error("opmask live differs from wide live");
    property p_live_on;
        xe_wr && privileged && caps.state_save && caps.foundation
            && wdata[XE_WIDE_HI:XE_OPMASK_LO] == XE_WIDE_ALL
            && wdata[XE_MID_HI:XE_SHORT_LO] == XE_NARROW_ALL |-> ##2 wide_state_live;
    endproperty
    a_live_on: assert property (p_live_on) else $error("full enable did not go live");
    property p_live_off;
        xe_wr && privileged && caps.state_save && wdata[2:1] != 2'h3 |-> ##2 !wide_state_live;
    endproperty
    a_live_off: assert property (p_live_off) else $error("narrow fields clear but live");
    property p_rise_cause;
        $rose(wide_state_live) |-> $past(xe_wr, 2);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("live rose without write");
    property p_fall_cause;
        $fell(wide_state_live) |-> $past(xe_wr, 2);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("live fell without write");
    property p_no_found;
        !caps.foundation && !$past(caps.foundation) |-> !wide_state_live;
    endproperty
    a_no_found: assert property (p_no_found) else $error("live without foundation");
    // main scenarios reached
    c_refuse: cover property (xe_wr && !privileged);
    c_rise: cover property ($rose(wide_state_live));
    c_fall: cover property ($fell(wide_state_live));
endmodule

bind vfe_top vfe_props i_vfe_props (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .privileged(privileged),
    .os_state_mgmt_enabled_flag(os_state_mgmt_enabled_flag), .caps(caps), .rdata(rdata),
    .enable_write_fault(enable_write_fault), .opmask_state_live(opmask_state_live),
    .wide_state_live(wide_state_live));

// file: bench/vfe_sw_model.sv
// software side: register bus accesses and the detection sequence
`timescale 1ns/1ps
module vfe_sw_model
    import vfe_pkg::*;
(
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr_en,
    output logic rd_en,
    output logic privileged
);
    // idle bus at time zero
    initial
    begin
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        privileged = 1'b0;
    end
    // one-cycle write, data scrambled once released
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic priv);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        privileged <= priv;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    // select leaf, subleaf zero, then read one result word
    task automatic query(input logic [31:0] lf, input logic [7:0] w, output logic [31:0] d);
        bus_write(ADDR_QUERY_LEAF, lf, privileged);
        bus_write(ADDR_QUERY_SUB, SUBLEAF_ZERO, privileged);
        bus_read(w, d);
    endtask
    // os flag, then enable fields, then foundation, group and length bits
    task automatic probe(input int grp_bit, input logic want_vl, output logic ok);
        logic [31:0] d;
        query(LEAF_BASIC, ADDR_RES_C, d);
        ok = d[BIT_OS_STATE];
        bus_read(ADDR_XE_LO, d);
        ok = ok && d[7:5] == XE_WIDE_ALL && d[2:1] == XE_NARROW_ALL;
        query(LEAF_EXT, ADDR_RES_B, d);
        ok = ok && d[BIT_FOUNDATION] && d[grp_bit];
        if (want_vl)
            ok = ok && d[BIT_REDUCED_LEN];
    endtask
endmodule

// file: bench/tb_top.sv
// self-checking bench for the vector feature enumeration top
`timescale 1ns/1ps
module tb_top
    import vfe_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic os_state_mgmt_enabled_flag;
    vfe_caps_s caps;
    vfe_caps_s cv;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_en;
    logic rd_en;
    logic privileged;
    logic [31:0] rdata;
    logic enable_write_fault;
    logic [NUM_OPMASK-1:0] opmask_state_live;
    logic wide_state_live;
    logic [31:0] d;
    logic ok;
    int num_errors = 0;
    int checks_done = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    vfe_top i_vfe_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .privileged(privileged),
        .os_state_mgmt_enabled_flag(os_state_mgmt_enabled_flag), .caps(caps), .rdata(rdata),
        .enable_write_fault(enable_write_fault), .opmask_state_live(opmask_state_live),
        .wide_state_live(wide_state_live));
    vfe_sw_model i_vfe_sw_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .privileged(privileged));
    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // counts, verdict, end of run
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // expected leaf 7 second word, siblings gated by foundation
    function automatic logic [31:0] exp_ext(input vfe_caps_s c);
        logic [31:0] b;
        b = 32'h0;
        b[BIT_FOUNDATION] = c.foundation;
        b[BIT_EXP_RECIP] = c.foundation & c.exp_recip;
        b[BIT_GATHER_PF] = c.foundation & c.gather_pf;
        b[BIT_CONFLICT] = c.foundation & c.conflict;
        b[BIT_DWORD_QWORD] = c.foundation & c.dword_qword;
        b[BIT_BYTE_WORD] = c.foundation & c.byte_word;
        b[BIT_REDUCED_LEN] = c.foundation & c.reduced_len;
        return b;
    endfunction
    // offer one instruction, read back fault and mask select
    task automatic check_instr(input vfe_group_e g, input logic [1:0] vl, input logic [2:0] form,
        input logic exp_fault);
        vfe_instr_s ins;
        ins = {g, vl, form, 3'h5};
        i_vfe_sw_model.bus_write(ADDR_CHECK, 32'(ins), 1'b1);
        repeat (2) @(posedge clk);
        i_vfe_sw_model.bus_read(ADDR_VERDICT, d);
        chk("verdict", {27'h0, 1'b1, exp_fault, 3'h5}, d & 32'h1F);
    endtask
    // hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        caps = 8'hFF;
        os_state_mgmt_enabled_flag = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        i_vfe_sw_model.bus_read(ADDR_XE_LO, d);
        chk("xe hidden", READ_UNMAPPED, d);
        os_state_mgmt_enabled_flag <= 1'b1;
        repeat (3) @(posedge clk);
        i_vfe_sw_model.query(LEAF_BASIC, ADDR_RES_C, d);
        chk("leaf1 c", 32'h0C00_0000, d & 32'h0C00_0000);
        i_vfe_sw_model.bus_read(ADDR_XE_LO, d);
        chk("xe reset", XE_RESET[31:0], d);
        // each strap alone with foundation, then foundation absent
        for (int i = 0; i < 9; i++)
        begin
            cv = (i == 8) ? 8'h7F : (8'h80 | (8'h01 << i));
            caps <= cv;
            i_vfe_sw_model.query(LEAF_EXT, ADDR_RES_B, d);
            chk("leaf7 b", exp_ext(cv), d);
        end
        caps <= 8'hFF;
        i_vfe_sw_model.bus_write(ADDR_XE_WRITE, 32'hE7, 1'b0);
        #1;
        chk("refuse pulse", 32'h1, 32'(enable_write_fault));
        i_vfe_sw_model.bus_read(ADDR_XE_LO, d);
        chk("xe kept", 32'h1, d);
        i_vfe_sw_model.bus_write(ADDR_XE_HI, 32'hFFFF_FFFF, 1'b1);
        i_vfe_sw_model.bus_write(ADDR_XE_WRITE, 32'hFF, 1'b1);
        i_vfe_sw_model.bus_read(ADDR_XE_LO, d);
        chk("xe masked", 32'hE7, d);
        i_vfe_sw_model.bus_read(ADDR_XE_HI, d);
        chk("xe high masked", 32'h0, d);
        i_vfe_sw_model.bus_read(ADDR_STATUS, d);
        chk("status", 32'h3, d);
        chk("opmask live", 32'hFF, 32'(opmask_state_live));
        i_vfe_sw_model.probe(BIT_CONFLICT, 1'b1, ok);
        chk("probe full", 32'h1, 32'(ok));
        check_instr(VFE_GRP_FOUND, VL_512, 3'b000, 1'b0);
        check_instr(VFE_GRP_CONFLICT, VL_256, 3'b000, 1'b0);
        check_instr(VFE_GRP_BW, VL_128, 3'b000, 1'b0);
        check_instr(VFE_GRP_ER, VL_512, 3'b000, 1'b0);
        check_instr(VFE_GRP_PF, VL_512, 3'b000, 1'b0);
        check_instr(VFE_GRP_FOUND, VL_256, 3'b100, 1'b0);
        check_instr(VFE_GRP_FOUND, VL_128, 3'b100, 1'b1);
        check_instr(VFE_GRP_DQ, VL_128, 3'b100, 1'b1);
        check_instr(VFE_GRP_OPMASK, VL_512, 3'b010, 1'b0);
        check_instr(VFE_GRP_OPMASK, VL_512, 3'b001, 1'b1);
        check_instr(VFE_GRP_FOUND, 2'h3, 3'b000, 1'b1);
        caps <= 8'hFD;
        check_instr(VFE_GRP_CONFLICT, VL_256, 3'b000, 1'b1);
        i_vfe_sw_model.probe(BIT_CONFLICT, 1'b1, ok);
        chk("probe no length", 32'h0, 32'(ok));
        i_vfe_sw_model.bus_write(ADDR_XE_WRITE, 32'hE1, 1'b1);
        repeat (2) @(posedge clk);
        chk("wide live off", 32'h0, 32'(wide_state_live));
        check_instr(VFE_GRP_FOUND, VL_512, 3'b000, 1'b1);
        check_instr(VFE_GRP_L1PF, VL_128, 3'b000, 1'b0);
        give_verdict();
    end
endmodule
